// ### hdl/ccm_regs.v
// chip configuration and station address register bank with eeprom load.
// assumes the serial host front end presents dword accesses with byte enables
// as single-cycle strobes on i_clk; the eeprom data pin is external and async.
//
// Notes on behaviour
// - every bit keeps its access type: read-only ignores writes, read/write stores.
// - chip configuration is read-only and shows strap and bonding, not software.
// - the eeprom data pin level is caught into configuration bit 9 after reset.
// - configuration bit 8 reads 1 because the host interface is serial peripheral.
// - configuration bit 0 reads 1 for the 32-pin package variant.
// - with an eeprom present, reset fills the address registers from word 1 on.
// - words 1, 2 and 3 load the low, middle and high address registers.
// - software access to the address registers never writes the eeprom.
// - the low address register is a 16-bit read/write least significant word.
// - each 16-bit register has its low byte at the even and high byte at the odd offset.
// - middle and high address registers are 16-bit read/write words.
`include "ccm_map.vh"
`default_nettype none

module ccm_regs #(
   parameter SPI_HOST = 1'b1,
   parameter PKG_32PIN = 1'b1,
   // arbitrary identifier values
   parameter [15:0] PHY_ID_LOW = 16'hA5A5,
   parameter [15:0] PHY_ID_HIGH = 16'h5A5A
) (
   input wire i_clk,
   input wire i_resetn,
   input wire [7:0] i_reg_addr,
   input wire [3:0] i_reg_be,
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire [31:0] i_reg_wdata,
   output reg [31:0] o_reg_rdata,
   output reg o_reg_rvalid,
   input wire i_eeprom_data_pin,
   output reg o_eeprom_data_pin,
   output reg o_eeprom_data_oe,
   output reg o_eeprom_sk,
   output reg o_eeprom_cs,
   output reg o_load_busy
);

   localparam [2:0] ST_STRAP = 3'h0;
   localparam [2:0] ST_START = 3'h1;
   localparam [2:0] ST_WAIT = 3'h2;
   localparam [2:0] ST_IDLE = 3'h3;

   reg rst_ff1;
   reg rst_ff2;
   wire rstn;
   reg pin_ff1;
   reg pin_ff2;
   reg pin_ff3;
   reg ee_present;
   reg [2:0] state;
   reg [1:0] word_sel;
   reg [15:0] station_address_low;
   reg [15:0] station_address_middle;
   reg [15:0] station_address_high;
   reg [15:0] phy_reset_control;
   reg [15:0] phy_basic_control;
   reg [15:0] autoneg_advertisement;
   reg [15:0] phy_special_control_cable_test;
   reg [15:0] port_control;
   reg [15:0] chip_configuration;
   reg [5:0] ee_addr;
   wire ee_start;
   wire ee_busy;
   wire ee_done;
   wire [15:0] ee_data;
   wire ee_cs;
   wire ee_sk;
   wire ee_dout;
   wire ee_oe;
   wire [15:0] lo_half;
   wire [15:0] hi_half;
   wire [1:0] lo_be;
   wire [1:0] hi_be;

   // reset release through two flip-flops
   always @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rst_ff1 <= 1'b0;
         rst_ff2 <= 1'b0;
      end
      else
      begin
         rst_ff1 <= 1'b1;
         rst_ff2 <= rst_ff1;
      end
   end
   assign rstn = rst_ff2;

   // eeprom data pin synchroniser, cleared during the reset hold and filled after it; the strap waits for two equal samples
   always @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         pin_ff1 <= 1'b0;
         pin_ff2 <= 1'b0;
         pin_ff3 <= 1'b0;
      end
      else
      begin
         pin_ff1 <= i_eeprom_data_pin;
         pin_ff2 <= pin_ff1;
         pin_ff3 <= pin_ff2;
      end
   end

   // strap capture and load sequence
   always @(posedge i_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= ST_STRAP;
         ee_present <= 1'b0;
         word_sel <= 2'h0;
         ee_addr <= 6'h00;
         o_load_busy <= 1'b1;
      end
      else
      begin
         case (state)
            ST_STRAP:
            begin
               if (pin_ff2 == pin_ff3)
               begin
                  ee_present <= pin_ff3;
                  if (pin_ff3)
                  begin
                     state <= ST_START;
                     ee_addr <= `CCM_EE_WORD_LOW;
                     word_sel <= 2'h0;
                  end
                  else
                  begin
                     state <= ST_IDLE;
                     o_load_busy <= 1'b0;
                  end
               end
            end
            ST_START:
               state <= ST_WAIT;
            ST_WAIT:
            begin
               if (ee_done)
               begin
                  if (word_sel == 2'h2)
                  begin
                     state <= ST_IDLE;
                     o_load_busy <= 1'b0;
                  end
                  else
                  begin
                     word_sel <= word_sel + 2'h1;
                     ee_addr <= ee_addr + 6'h01;
                     state <= ST_START;
                  end
               end
            end
            ST_IDLE:
               state <= ST_IDLE;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   assign ee_start = (state == ST_START) && !ee_busy;

   // the eeprom is only ever read, so software traffic cannot alter its contents
   ccm_ee_reader u_reader (
      .i_clk(i_clk),
      .i_rstn(rstn),
      .i_start(ee_start),
      .i_addr(ee_addr),
      .i_ee_din(pin_ff3),
      .o_busy(ee_busy),
      .o_done(ee_done),
      .o_data(ee_data),
      .o_ee_cs(ee_cs),
      .o_ee_sk(ee_sk),
      .o_ee_dout(ee_dout),
      .o_ee_oe(ee_oe)
   );

   always @(posedge i_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         o_eeprom_data_pin <= 1'b0;
         o_eeprom_data_oe <= 1'b0;
         o_eeprom_sk <= 1'b0;
         o_eeprom_cs <= 1'b0;
      end
      else
      begin
         o_eeprom_data_pin <= ee_dout;
         o_eeprom_data_oe <= ee_oe;
         o_eeprom_sk <= ee_sk;
         o_eeprom_cs <= ee_cs;
      end
   end

   // byte lanes: the even 16-bit register sits in bits 15:0, the odd one in 31:16
   assign lo_half = i_reg_wdata[15:0];
   assign hi_half = i_reg_wdata[31:16];
   assign lo_be = i_reg_be[1:0];
   assign hi_be = i_reg_be[3:2];

   function [15:0] merge;
      input [15:0] old;
      input [7:0] off;
      input [7:0] addr;
      input [1:0] lbe;
      input [1:0] hbe;
      input [15:0] ldat;
      input [15:0] hdat;
      reg [1:0] be;
      reg [15:0] dat;
      begin
         be = off[1] ? hbe : lbe;
         dat = off[1] ? hdat : ldat;
         if (addr[7:2] != off[7:2])
            be = 2'b00;
         merge = {be[1] ? dat[15:8] : old[15:8], be[0] ? dat[7:0] : old[7:0]};
      end
   endfunction

   // read/write registers; a load completion in the same cycle as a write wins
   always @(posedge i_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         station_address_low <= `CCM_RST_MAC;
         station_address_middle <= `CCM_RST_MAC;
         station_address_high <= `CCM_RST_MAC;
         phy_reset_control <= `CCM_RST_PHY_RST;
         phy_basic_control <= `CCM_RST_PHY_BCTL;
         autoneg_advertisement <= `CCM_RST_ANEG_ADV;
         phy_special_control_cable_test <= `CCM_RST_PHY_SPEC;
         port_control <= `CCM_RST_PORT_CTL;
      end
      else
      begin
         if (i_reg_wr)
         begin
            station_address_low <= merge(station_address_low, `CCM_OFF_MAC_LOW,
               i_reg_addr, lo_be, hi_be, lo_half, hi_half);
            station_address_middle <= merge(station_address_middle, `CCM_OFF_MAC_MID,
               i_reg_addr, lo_be, hi_be, lo_half, hi_half);
            station_address_high <= merge(station_address_high, `CCM_OFF_MAC_HIGH,
               i_reg_addr, lo_be, hi_be, lo_half, hi_half);
            phy_reset_control <= merge(phy_reset_control, `CCM_OFF_PHY_RST,
               i_reg_addr, lo_be, hi_be, lo_half, hi_half);
            phy_basic_control <= merge(phy_basic_control, `CCM_OFF_PHY_BCTL,
               i_reg_addr, lo_be, hi_be, lo_half, hi_half);
            autoneg_advertisement <= merge(autoneg_advertisement, `CCM_OFF_ANEG_ADV,
               i_reg_addr, lo_be, hi_be, lo_half, hi_half);
            phy_special_control_cable_test <= merge(phy_special_control_cable_test,
               `CCM_OFF_PHY_SPEC, i_reg_addr, lo_be, hi_be, lo_half, hi_half);
            port_control <= merge(port_control, `CCM_OFF_PORT_CTL,
               i_reg_addr, lo_be, hi_be, lo_half, hi_half);
         end
         if (ee_done && state == ST_WAIT)
         begin
            case (word_sel)
               2'h0: station_address_low <= ee_data;
               2'h1: station_address_middle <= ee_data;
               2'h2: station_address_high <= ee_data;
               default: station_address_high <= station_address_high;
            endcase
         end
      end
   end

   // configuration word: read-only, fed only by straps and bonding
   always @*
   begin
      chip_configuration = 16'h0000;
      chip_configuration[`CCM_CFG_BIT_EEPROM] = ee_present;
      chip_configuration[`CCM_CFG_BIT_SPI] = SPI_HOST;
      chip_configuration[`CCM_CFG_BIT_PKG32] = PKG_32PIN;
   end

   function [15:0] rd16;
      input [7:0] off;
      begin
         case (off)
            `CCM_OFF_CHIP_CFG: rd16 = chip_configuration;
            `CCM_OFF_MAC_LOW: rd16 = station_address_low;
            `CCM_OFF_MAC_MID: rd16 = station_address_middle;
            `CCM_OFF_MAC_HIGH: rd16 = station_address_high;
            `CCM_OFF_PHY_RST: rd16 = phy_reset_control;
            `CCM_OFF_PHY_BCTL: rd16 = phy_basic_control;
            `CCM_OFF_PHY_BSTS: rd16 = `CCM_RST_PHY_BSTS;
            `CCM_OFF_PHY_IDL: rd16 = PHY_ID_LOW;
            `CCM_OFF_PHY_IDH: rd16 = PHY_ID_HIGH;
            `CCM_OFF_ANEG_ADV: rd16 = autoneg_advertisement;
            `CCM_OFF_ANEG_LP: rd16 = `CCM_RST_ANEG_LP;
            `CCM_OFF_PHY_SPEC: rd16 = phy_special_control_cable_test;
            `CCM_OFF_PORT_CTL: rd16 = port_control;
            `CCM_OFF_PORT_STS: rd16 = `CCM_RST_PORT_STS;
            default: rd16 = 16'h0000;
         endcase
      end
   endfunction

   // read answer one cycle after the strobe; disabled byte lanes read zero
   always @(posedge i_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         o_reg_rdata <= 32'h00000000;
         o_reg_rvalid <= 1'b0;
      end
      else
      begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd)
         begin
            o_reg_rdata[15:0] <= rd16({i_reg_addr[7:2], 2'b00}) &
               {{8{i_reg_be[1]}}, {8{i_reg_be[0]}}};
            o_reg_rdata[31:16] <= rd16({i_reg_addr[7:2], 2'b10}) &
               {{8{i_reg_be[3]}}, {8{i_reg_be[2]}}};
         end
      end
   end

endmodule // ccm_regs

`default_nettype wire

// ### hdl/ccm_map.vh
// register map, field positions, reset values and timing counts of the
// chip configuration and station address register bank.
// assumes a 250 MHz system clock and a three-wire serial eeprom of 16-bit words.
`ifndef CCM_MAP_VH
`define CCM_MAP_VH

// byte offsets of the 16-bit registers
`define CCM_OFF_CHIP_CFG 8'h08
`define CCM_OFF_MAC_LOW 8'h10
`define CCM_OFF_MAC_MID 8'h12
`define CCM_OFF_MAC_HIGH 8'h14
`define CCM_OFF_PHY_RST 8'hD8
`define CCM_OFF_PHY_BCTL 8'hE4
`define CCM_OFF_PHY_BSTS 8'hE6
`define CCM_OFF_PHY_IDL 8'hE8
`define CCM_OFF_PHY_IDH 8'hEA
`define CCM_OFF_ANEG_ADV 8'hEC
`define CCM_OFF_ANEG_LP 8'hEE
`define CCM_OFF_PHY_SPEC 8'hF4
`define CCM_OFF_PORT_CTL 8'hF6
`define CCM_OFF_PORT_STS 8'hF8

// reset values
`define CCM_RST_PHY_RST 16'h0000
`define CCM_RST_PHY_BCTL 16'h3120
`define CCM_RST_PHY_BSTS 16'h7808
`define CCM_RST_ANEG_ADV 16'h05E1
`define CCM_RST_ANEG_LP 16'h0001
`define CCM_RST_PHY_SPEC 16'h0000
`define CCM_RST_PORT_CTL 16'h00FF
`define CCM_RST_PORT_STS 16'h8080
`define CCM_RST_MAC 16'h0000

// chip configuration field positions
`define CCM_CFG_BIT_EEPROM 9
`define CCM_CFG_BIT_SPI 8
`define CCM_CFG_BIT_PKG32 0

// eeprom word addresses of the station address
`define CCM_EE_WORD_LOW 6'h01
`define CCM_EE_WORD_MID 6'h02
`define CCM_EE_WORD_HIGH 6'h03

// eeprom read command: start bit and read opcode, then six address bits
`define CCM_EE_CMD_READ 3'h6
`define CCM_EE_CMD_BITS 5'h09
`define CCM_EE_LAST_BIT 5'h19

// eeprom serial clock half period, a least time rounded up to cycles
`define CCM_CLK_MHZ 250
`define CCM_EE_HALF_NS 500
`define CCM_EE_HALF_CYC ((`CCM_EE_HALF_NS * `CCM_CLK_MHZ + 999) / 1000)

`endif

// ### hdl/ccm_ee_reader.v
// reads one 16-bit word from a three-wire serial eeprom.
// assumes i_ee_din is already synchronised to i_clk and reset is synchronous-released.
`include "ccm_map.vh"
`default_nettype none

module ccm_ee_reader (
   input wire i_clk,
   input wire i_rstn,
   input wire i_start,
   input wire [5:0] i_addr,
   input wire i_ee_din,
   output reg o_busy,
   output reg o_done,
   output reg [15:0] o_data,
   output reg o_ee_cs,
   output reg o_ee_sk,
   output reg o_ee_dout,
   output reg o_ee_oe
);

   localparam integer HALF_CYC = `CCM_EE_HALF_CYC;
   localparam [7:0] HALF = HALF_CYC[7:0];
   localparam [4:0] LAST = `CCM_EE_LAST_BIT;
   localparam [4:0] NCMD = `CCM_EE_CMD_BITS;

   reg [7:0] tick;
   reg [4:0] idx;
   reg [8:0] cmd;
   wire tick_end;

   assign tick_end = (tick == HALF - 8'h01);

   always @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_data <= 16'h0000;
         o_ee_cs <= 1'b0;
         o_ee_sk <= 1'b0;
         o_ee_dout <= 1'b0;
         o_ee_oe <= 1'b0;
         tick <= 8'h00;
         idx <= 5'h00;
         cmd <= 9'h000;
      end
      else
      begin
         o_done <= 1'b0;
         if (!o_busy)
         begin
            if (i_start)
            begin
               o_busy <= 1'b1;
               o_ee_cs <= 1'b1;
               o_ee_oe <= 1'b1;
               cmd <= {`CCM_EE_CMD_READ, i_addr};
               o_ee_dout <= 1'b1;
               tick <= 8'h00;
               idx <= 5'h00;
            end
         end
         else if (!tick_end)
            tick <= tick + 8'h01;
         else
         begin
            tick <= 8'h00;
            if (!o_ee_sk)
            begin
               // data is sampled just before the rising edge; bit 9 is the dummy zero
               if (idx > NCMD)
                  o_data <= {o_data[14:0], i_ee_din};
               o_ee_sk <= 1'b1;
            end
            else
            begin
               o_ee_sk <= 1'b0;
               if (idx == LAST)
               begin
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
                  o_ee_cs <= 1'b0;
                  o_ee_oe <= 1'b0;
                  o_ee_dout <= 1'b0;
               end
               else
               begin
                  idx <= idx + 5'h01;
                  cmd <= {cmd[7:0], 1'b0};
                  o_ee_dout <= cmd[7];
                  o_ee_oe <= (idx + 5'h01 < NCMD);
               end
            end
         end
      end
   end

endmodule // ccm_ee_reader

`default_nettype wire

// ### verification/ccm_regs_checker.sv
// assertions on the register bank ports and the eeprom load sequence.
// assumes it is bound to ccm_regs with its parameters handed on.
`include "ccm_map.vh"
`default_nettype none
module ccm_regs_checker #(
   parameter SPI_HOST = 1'b1,
   parameter PKG_32PIN = 1'b1,
   parameter [15:0] PHY_ID_LOW = 16'hA5A5,
   parameter [15:0] PHY_ID_HIGH = 16'h5A5A
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [7:0] i_reg_addr,
   input wire logic [3:0] i_reg_be,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [31:0] i_reg_wdata,
   input wire logic [31:0] o_reg_rdata,
   input wire logic o_reg_rvalid,
   input wire logic i_eeprom_data_pin,
   input wire logic o_eeprom_data_pin,
   input wire logic o_eeprom_data_oe,
   input wire logic o_eeprom_sk,
   input wire logic o_eeprom_cs,
   input wire logic o_load_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic seen_cs;
   logic cs_q;
   logic [4:0] rises;
   logic [1:0] words;
   wire [8:0] cmd = {3'b110, 4'h0, words} + 9'h001;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // sk rises counted inside a frame, frames counted since reset
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         seen_cs <= 1'b0;
         cs_q <= 1'b0;
         rises <= 5'h00;
         words <= 2'h0;
      end
      else
      begin
         cs_q <= o_eeprom_cs;
         seen_cs <= seen_cs | o_eeprom_cs;
         if (cs_q && !o_eeprom_cs)
            words <= words + 2'h1;
         if (!o_eeprom_cs)
            rises <= 5'h00;
         else if ($rose(o_eeprom_sk))
            rises <= rises + 5'h01;
      end
   end
   sequence hdr_rise;
      $rose(o_eeprom_sk) && rises < 5'd9;
   endsequence
   sequence high_phase;
      ##125 $fell(o_eeprom_sk);
   endsequence
   function automatic logic rd_at(input logic [7:0] a);
      rd_at = i_reg_rd && i_reg_addr[7:2] == a[7:2] && i_reg_be == 4'hF;
   endfunction
   read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read strobe without answer");
   cfg_bits_a: assert property (rd_at(8'h08) && !o_load_busy |=>
      o_reg_rdata == {22'h0, seen_cs, 1'(SPI_HOST), 7'h0, 1'(PKG_32PIN)})
      else $error("configuration bits wrong");
   status_const_a: assert property (rd_at(8'hE4) |=>
      o_reg_rdata[31:16] == `CCM_RST_PHY_BSTS) else $error("status word changed");
   ident_const_a: assert property (rd_at(8'hE8) |=>
      o_reg_rdata == {PHY_ID_HIGH, PHY_ID_LOW}) else $error("identifier wrong");
   reserved_zero_a: assert property (rd_at(8'h00) |=> o_reg_rdata == 32'h0)
      else $error("reserved read not zero");
   idle_link_a: assert property (!o_load_busy |-> !o_eeprom_cs)
      else $error("eeprom selected after load");
   frame_start_a: assert property ($rose(o_eeprom_cs) |->
      o_eeprom_data_oe && o_eeprom_data_pin && !o_eeprom_sk && words < 2'd3)
      else $error("frame start wrong");
   header_bits_a: assert property (hdr_rise |->
      o_eeprom_data_oe && o_eeprom_data_pin == cmd[4'd8 - rises[3:0]])
      else $error("command bit wrong");
   data_phase_a: assert property ($rose(o_eeprom_sk) && rises >= 5'd9 |->
      !o_eeprom_data_oe) else $error("data line driven in data phase");
   sk_half_a: assert property ($rose(o_eeprom_sk) |-> high_phase)
      else $error("serial clock half period wrong");
   load_end_a: assert property ($fell(o_load_busy) |=>
      words == (seen_cs ? 2'd3 : 2'd0)) else $error("word count at load end");
endmodule // ccm_regs_checker
bind ccm_regs ccm_regs_checker #(.SPI_HOST(SPI_HOST), .PKG_32PIN(PKG_32PIN),
   .PHY_ID_LOW(PHY_ID_LOW), .PHY_ID_HIGH(PHY_ID_HIGH)) i_chk (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr), .i_reg_be(i_reg_be),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
   .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
   .i_eeprom_data_pin(i_eeprom_data_pin), .o_eeprom_data_pin(o_eeprom_data_pin),
   .o_eeprom_data_oe(o_eeprom_data_oe), .o_eeprom_sk(o_eeprom_sk),
   .o_eeprom_cs(o_eeprom_cs), .o_load_busy(o_load_busy));
`default_nettype wire

// ### verification/ccm_ee_model.sv
// behavioural three-wire serial eeprom answering 16-bit word reads.
// assumes the board strap sets the data line whenever nobody drives it.
`default_nettype none
module ccm_ee_model #(
   parameter logic [15:0] W1 = 16'h89AB,
   parameter logic [15:0] W2 = 16'h4567,
   parameter logic [15:0] W3 = 16'h0123
) (
   input wire logic i_cs,
   input wire logic i_sk,
   input wire logic i_din,
   output var logic o_drive,
   output var logic o_dout,
   output var logic o_bad
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   logic [8:0] hdr = 9'h000;
   logic [15:0] word = 16'h0000;
   initial
   begin
      o_drive = 1'b0;
      o_dout = 1'b0;
      o_bad = 1'b0;
   end
   always @(posedge i_sk)
   begin
      if (i_cs)
      begin
         cnt = cnt + 1;
         if (cnt <= 9)
            hdr = {hdr[7:0], i_din};
         if (cnt == 9)
         begin
            // only reads are expected, a write command marks a fault
            o_bad = o_bad | (hdr[8:6] != 3'b110);
            word = hdr[5:0] == 6'h01 ? W1 : hdr[5:0] == 6'h02 ? W2 : W3;
            o_dout = 1'b0;
            o_drive = 1'b1;
         end
         else if (cnt >= 10 && cnt <= 25)
            o_dout = word[25 - cnt];
         else if (cnt >= 26)
            o_drive = 1'b0;
      end
   end
   always @(negedge i_cs)
   begin
      cnt = 0;
      o_drive = 1'b0;
   end
endmodule // ccm_ee_model
`default_nettype wire

// ### verification/chip_config_mac_addr_regs_test.sv
// self-checking bench: register map model, strap, eeprom load, random byte access.
// assumes ccm_regs with the eeprom model on its link and a strap on the data line.
`include "ccm_map.vh"
`default_nettype none
module chip_config_mac_addr_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [15:0] ID_LOW = 16'h3C69; // arbitrary value
   localparam [15:0] ID_HIGH = 16'h0F1E; // arbitrary value
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [3:0] be = 4'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic strap = 1'b0;
   logic [7:0] ra = 8'h00;
   logic [3:0] rbe = 4'hF;
   logic [31:0] seed = 32'h410333A1;
   logic [15:0] mdl [0:127];
   logic [15:0] rwm [0:127];
   int bad_count = 0;
   int n_compared = 0;
   int cs_rises = 0;
   wire [31:0] rdata;
   wire rvalid, ee_q, ee_oe, ee_sk, ee_cs, busy, m_drv, m_q, m_bad;
   wire pin = ee_oe ? ee_q : (m_drv ? m_q : strap);
   always #2 i_clk = ~i_clk;
   always @(posedge ee_cs) cs_rises++;
   ccm_regs #(.SPI_HOST(1'b1), .PKG_32PIN(1'b1), .PHY_ID_LOW(ID_LOW), .PHY_ID_HIGH(ID_HIGH))
   i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_reg_addr(addr), .i_reg_be(be),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .o_reg_rvalid(rvalid), .i_eeprom_data_pin(pin), .o_eeprom_data_pin(ee_q),
      .o_eeprom_data_oe(ee_oe), .o_eeprom_sk(ee_sk), .o_eeprom_cs(ee_cs),
      .o_load_busy(busy));
   ccm_ee_model i_ee (.i_cs(ee_cs), .i_sk(ee_sk), .i_din(pin), .o_drive(m_drv),
      .o_dout(m_q), .o_bad(m_bad));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic setr(input logic [7:0] off, input logic [15:0] v, input logic w);
      mdl[off[7:1]] = v;
      rwm[off[7:1]] = w ? 16'hFFFF : 16'h0000;
   endtask
   task automatic init_model(input logic s);
      for (int i = 0; i < 128; i++)
         setr(8'(2 * i), 16'h0000, 1'b0);
      setr(8'h08, {6'h00, s, 1'b1, 7'h00, 1'b1}, 1'b0);
      setr(8'h10, s ? 16'h89AB : 16'h0000, 1'b1);
      setr(8'h12, s ? 16'h4567 : 16'h0000, 1'b1);
      setr(8'h14, s ? 16'h0123 : 16'h0000, 1'b1);
      setr(8'hD8, 16'h0000, 1'b1);
      setr(8'hE4, 16'h3120, 1'b1);
      setr(8'hE6, 16'h7808, 1'b0);
      setr(8'hE8, ID_LOW, 1'b0);
      setr(8'hEA, ID_HIGH, 1'b0);
      setr(8'hEC, 16'h05E1, 1'b1);
      setr(8'hEE, 16'h0001, 1'b0);
      setr(8'hF4, 16'h0000, 1'b1);
      setr(8'hF6, 16'h00FF, 1'b1);
      setr(8'hF8, 16'h8080, 1'b0);
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      logic [6:0] i;
      addr = a;
      be = b;
      wdata = d;
      wr = 1'b1;
      @(posedge i_clk);
      #1;
      wr = 1'b0;
      for (int k = 0; k < 4; k++)
      begin
         i = {a[7:2], k[1]};
         if (b[k])
            mdl[i][8*k[0] +: 8] = (mdl[i][8*k[0] +: 8] & ~rwm[i][8*k[0] +: 8])
               | (d[8*k +: 8] & rwm[i][8*k[0] +: 8]);
      end
   endtask
   task automatic read_cmp(input logic [7:0] a);
      addr = a;
      be = rbe;
      rd = 1'b1;
      @(posedge i_clk);
      #1;
      check("read valid", 32'h1, {31'h0, rvalid});
      check($sformatf("offset %h", a), {mdl[{a[7:2], 1'b1}], mdl[{a[7:2], 1'b0}]}
         & {{8{rbe[3]}}, {8{rbe[2]}}, {8{rbe[1]}}, {8{rbe[0]}}}, rdata);
      rd = 1'b0;
      @(posedge i_clk);
      #1;
   endtask
   task automatic do_reset(input logic s);
      int n;
      strap = s;
      i_resetn = 1'b0;
      cs_rises = 0;
      repeat (6) @(posedge i_clk);
      #1;
      i_resetn = 1'b1;
      init_model(s);
      n = 0;
      repeat (3) @(posedge i_clk);
      while (busy !== 1'b0 && n < 25000)
      begin
         @(posedge i_clk);
         n++;
      end
      #1;
      check("load busy", 32'h0, {31'h0, busy});
      check("eeprom frames", s ? 3 : 0, cs_rises);
   endtask
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #240000;
      bad_count++;
      $display("Error watchdog expected end seen hang");
      give_verdict();
   end
   initial
   begin
      do_reset(1'b0);
      read_cmp(8'h08);
      read_cmp(8'h10);
      read_cmp(8'h14);
      $display("test no eeprom done");
      do_reset(1'b1);
      read_cmp(8'h08);
      read_cmp(8'h10);
      read_cmp(8'h14);
      reg_write(8'h14, 4'hF, {rdata[31:16], 16'h5A3C});
      read_cmp(8'h14);
      $display("test eeprom load done");
      for (int a = 8'hD8; a <= 8'hF8; a += 4)
         read_cmp(8'(a));
      read_cmp(8'h00);
      reg_write(8'h08, 4'hF, 32'hFFFF_FCFE);
      read_cmp(8'h08);
      $display("test defaults done");
      for (int n = 0; n < 300; n++)
      begin
         seed = lfsr(seed);
         ra = seed[12] ? {5'b00010, seed[2], 2'b00} : (seed[7:0] & 8'hFC);
         reg_write(ra, seed[11:8], lfsr(seed));
         rbe = seed[19:16];
         read_cmp(ra);
      end
      check("eeprom frames after access", 32'd3, cs_rises);
      check("eeprom command", 32'h0, {31'h0, m_bad});
      $display("test random access done");
      give_verdict();
   end
endmodule // chip_config_mac_addr_regs_test
`default_nettype wire
